// ==== verilog/atc_pkg.sv ====
// constants, types and decode functions for the converter control block
// What this block does
// - rising edge on selected trigger source sets the start bit in hardware
// - only rising edges start conversions; a steady high level starts once
// - select codes 1-4 and 16-17 map to timer period and overflow sources
// - codes 5-15 map to timer-2 match, comparators, logic cells, capture units
// - select code zero disables auto-triggering; software start only
// - timer overflow event is the moment the timer sets its flag
// - trigger edges are ignored while the device sleeps
// - channel codes 3f,3e,3d,3c route reference, dac, temperature, ground
// - port A, B, C channel codes; reserved codes connect no channel
// - software writes start bit; held during conversion, cleared at end
// - enable bit turns converter on; clear means converter off
// - format bit picks right or left justified result with zero fill
// - clock field picks system clock /2,/8,/32,/4,/16,/64 or rc oscillator
// - negative reference bit picks ground or pin; disabled means all open
// - positive reference field picks supply, pin or fixed reference
// - on completion clear start bit, set flag, load result registers
// - a full conversion takes twelve conversion clock periods
// - start bit cleared early stops and loads partial result, filled
package atc_pkg;

    // ==========================================================
    // register map, byte addresses of 32-bit words
    localparam logic [7:0] ATC_ADDR_CTRL0 = 8'h00;
    localparam logic [7:0] ATC_ADDR_CTRL1 = 8'h04;
    localparam logic [7:0] ATC_ADDR_TRIG = 8'h08;
    localparam logic [7:0] ATC_ADDR_RESH = 8'h0c;
    localparam logic [7:0] ATC_ADDR_RESL = 8'h10;
    localparam logic [7:0] ATC_ADDR_STAT = 8'h14;

    // ==========================================================
    // field positions and reset values
    localparam int ATC_EN_BIT = 0;
    localparam int ATC_GO_BIT = 1;
    localparam int ATC_CHAN_LSB = 2;
    localparam int ATC_FMT_BIT = 7;
    localparam int ATC_CS_LSB = 4;
    localparam int ATC_NREF_BIT = 2;
    localparam int ATC_PREF_LSB = 0;
    localparam int ATC_FLAG_BIT = 0;
    localparam int ATC_BUSY_BIT = 1;
    localparam logic [7:0] ATC_CTRL_RESET = 8'h00;

    // ==========================================================
    // conversion timing and codes
    localparam logic [3:0] ATC_CONV_PERIODS = 4'hc;
    localparam logic [3:0] ATC_RES_BITS = 4'ha;
    localparam logic [4:0] ATC_TRIG_NONE = 5'h00;
    localparam logic [2:0] ATC_CS_RC = 3'h3;

    typedef enum logic {ATC_CV_IDLE, ATC_CV_RUN} atc_conv_t;

    // system clock division for a clock code; rc codes return zero
    function automatic logic [6:0] atc_period_div(input logic [2:0] code);
        unique case (code)
            3'h0: atc_period_div = 7'h02;
            3'h1: atc_period_div = 7'h08;
            3'h2: atc_period_div = 7'h20;
            3'h4: atc_period_div = 7'h04;
            3'h5: atc_period_div = 7'h10;
            3'h6: atc_period_div = 7'h40;
            default: atc_period_div = 7'h00;
        endcase
    endfunction

    // codes 011 and 111 select the dedicated rc oscillator
    function automatic logic atc_is_rc(input logic [2:0] code);
        atc_is_rc = (code[1:0] == ATC_CS_RC[1:0]);
    endfunction

    // a channel code that connects some input to the sample stage
    function automatic logic atc_chan_valid(input logic [5:0] code);
        atc_chan_valid = (code <= 6'h05 && code != 6'h03)
            || (code >= 6'h0c && code <= 6'h17)
            || (code >= 6'h3c);
    endfunction

endpackage

// ==== verilog/atc_trig.sv ====
// trigger source selector with synchroniser and rising edge detector
`timescale 1ns/1ps
module atc_trig
    import atc_pkg::*;
#(
    parameter int TRIG_N = 18
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [4:0] sel,
    input wire logic [TRIG_N-1:0] src,
    output logic edge_pulse
);
    logic pick;
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;

    if (TRIG_N < 18 || TRIG_N > 32)
        $error("atc_trig: TRIG_N must lie in 18..32");

    // ==========================================================
    // source mux; index equals select code, code zero unwired
    // timer inputs are their interrupt flags, so a flag set is the edge
    always_comb
    begin
        pick = 1'b0;
        if (sel != ATC_TRIG_NONE && 32'(sel) < TRIG_N)
            pick = src[sel];
    end

    // two-stage synchroniser then one history flop
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
        end
        else
        begin
            s1_reg <= pick;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // one pulse per rising edge; a held level gives no more
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            edge_pulse <= 1'b0;
        else
            edge_pulse <= s2_reg & ~s3_reg;
    end

    // ==========================================================
    // checks
    a_edge_single: assert property (@(posedge clk) disable iff (rst)
        edge_pulse |=> !edge_pulse)
        else $error("trigger pulse lasted more than one cycle");
    a_zero_no_trig: assert property (@(posedge clk) disable iff (rst)
        (sel == ATC_TRIG_NONE) [*3] |=> !edge_pulse)
        else $error("trigger pulse with auto-trigger off");
endmodule

// ==== verilog/atc_sar.sv ====
// successive approximation sequencer counting conversion clock periods
`timescale 1ns/1ps
module atc_sar
    import atc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic period_tick,
    input wire logic go,
    input wire logic comp_in,
    output logic busy,
    output logic sample,
    output logic [9:0] trial,
    output logic load,
    output logic complete,
    output logic [9:0] result
);
    atc_conv_t state_reg;
    logic [3:0] period_reg;
    logic [3:0] done_reg;
    logic last_reg;
    logic [9:0] fill;

    // ==========================================================
    // partial result: undecided bits copy the last decided bit
    always_comb
    begin
        fill = trial;
        for (int i = 0; i < 10; i++)
            if (32'(i) < 32'(ATC_RES_BITS - done_reg))
                fill[i] = last_reg;
    end

    assign busy = (state_reg == ATC_CV_RUN);

    // sequencer: tick 0 ends sampling, ticks 1..10 decide bits,
    // tick 11 closes the twelve-period conversion
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_reg <= ATC_CV_IDLE;
            period_reg <= 4'h0;
            done_reg <= 4'h0;
            last_reg <= 1'b0;
            sample <= 1'b0;
            trial <= 10'h000;
            load <= 1'b0;
            complete <= 1'b0;
            result <= 10'h000;
        end
        else
        begin
            load <= 1'b0;
            unique case (state_reg)
                ATC_CV_IDLE:
                    if (go && !load) // start bit still up on the load cycle
                    begin
                        state_reg <= ATC_CV_RUN;
                        period_reg <= 4'h0;
                        done_reg <= 4'h0;
                        last_reg <= 1'b0;
                        sample <= 1'b1;
                        trial <= 10'h000;
                    end
                ATC_CV_RUN:
                    if (!go)
                    begin
                        state_reg <= ATC_CV_IDLE;
                        sample <= 1'b0;
                        load <= 1'b1;
                        complete <= 1'b0;
                        result <= fill;
                    end
                    else if (period_tick)
                    begin
                        period_reg <= period_reg + 4'h1;
                        if (period_reg == 4'h0)
                        begin
                            sample <= 1'b0;
                            trial <= 10'h200;
                        end
                        else if (period_reg <= ATC_RES_BITS)
                        begin
                            trial[ATC_RES_BITS - period_reg] <= comp_in;
                            if (period_reg < ATC_RES_BITS)
                                trial[ATC_RES_BITS - period_reg - 4'h1] <= 1'b1;
                            last_reg <= comp_in;
                            done_reg <= done_reg + 4'h1;
                        end
                        else if (period_reg == ATC_CONV_PERIODS - 4'h1)
                        begin
                            state_reg <= ATC_CV_IDLE;
                            load <= 1'b1;
                            complete <= 1'b1;
                            result <= trial;
                        end
                    end
            endcase
        end
    end

    // ==========================================================
    // checks
    a_conv_twelve: assert property (@(posedge clk) disable iff (rst)
        load && complete |-> $past(period_reg) == ATC_CONV_PERIODS - 4'h1
            && $past(period_tick))
        else $error("conversion did not last twelve periods");
    a_abort_loads: assert property (@(posedge clk) disable iff (rst)
        busy && !go |=> load && !complete && !busy)
        else $error("early stop did not load a partial result");
    c_full_conv: cover property (@(posedge clk) disable iff (rst)
        load && complete);
    c_abort: cover property (@(posedge clk) disable iff (rst)
        load && !complete);
endmodule

// ==== verilog/atc_top.sv ====
// converter control: registers, trigger start, clock divider, result load
//
// Our own choices: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
module atc_top
    import atc_pkg::*;
#(
    parameter int TRIG_N = 18
)
(
    input wire logic CLOCK,
    input wire logic RESET,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    input wire logic [TRIG_N-1:0] TRIG_SRC,
    input wire logic SLEEP,
    input wire logic RC_TICK,
    input wire logic COMP_IN,
    output logic ANA_ENABLE,
    output logic ANA_MUX_CONNECT,
    output logic [5:0] ANA_CHANNEL,
    output logic ANA_NREF_EXT,
    output logic [1:0] ANA_PREF_SEL,
    output logic ANA_RC_SEL,
    output logic ANA_SAMPLE,
    output logic [9:0] ANA_TRIAL,
    output logic CONV_DONE_FLAG
);
    logic [7:0] ctrl1_reg;
    logic [4:0] trig_sel_reg;
    logic [5:0] chan_reg;
    logic en_reg;
    logic go_reg;
    logic flag_reg;
    logic [7:0] resh_reg;
    logic [7:0] resl_reg;
    logic [6:0] div_reg;
    logic period_tick_reg;
    logic wr_fire;
    logic wr_lane;
    logic trig_edge;
    logic go_set;
    logic go_clr;
    logic rc_mode;
    logic busy;
    logic load;
    logic complete;
    logic [9:0] result;
    logic [7:0] rd_data;

    // ==========================================================
    // bus side: write lands on the edge where ack is seen high
    assign wr_fire = WB_CYC_I & WB_STB_I & WB_WE_I & WB_ACK_O;
    assign wr_lane = wr_fire & WB_SEL_I[0];
    assign rc_mode = atc_is_rc(ctrl1_reg[ATC_CS_LSB +: 3]);

    // single-cycle ack, dropped the cycle after it is given
    always_ff @(posedge CLOCK or posedge RESET)
    begin
        if (RESET)
            WB_ACK_O <= 1'b0;
        else
            WB_ACK_O <= WB_CYC_I & WB_STB_I & ~WB_ACK_O;
    end

    // read mux; unmapped words read as zero
    always_comb
    begin
        unique case (WB_ADR_I)
            ATC_ADDR_CTRL0: rd_data = {chan_reg, go_reg, en_reg};
            ATC_ADDR_CTRL1: rd_data = {ctrl1_reg[7:4], 1'b0, ctrl1_reg[2:0]};
            ATC_ADDR_TRIG: rd_data = {3'h0, trig_sel_reg};
            ATC_ADDR_RESH: rd_data = resh_reg;
            ATC_ADDR_RESL: rd_data = resl_reg;
            ATC_ADDR_STAT: rd_data = {6'h00, busy, flag_reg};
            default: rd_data = 8'h00;
        endcase
    end

    // read data registered alongside the ack
    always_ff @(posedge CLOCK or posedge RESET)
    begin
        if (RESET)
            WB_DAT_O <= 32'h0000_0000;
        else if (WB_CYC_I && WB_STB_I && !WB_WE_I && !WB_ACK_O)
            WB_DAT_O <= {24'h00_0000, rd_data};
    end

    // ==========================================================
    // configuration registers
    always_ff @(posedge CLOCK or posedge RESET)
    begin
        if (RESET)
        begin
            ctrl1_reg <= ATC_CTRL_RESET;
            trig_sel_reg <= ATC_CTRL_RESET[4:0];
            chan_reg <= ATC_CTRL_RESET[7:2];
            en_reg <= 1'b0;
        end
        else if (wr_lane)
        begin
            if (WB_ADR_I == ATC_ADDR_CTRL0)
            begin
                chan_reg <= WB_DAT_I[ATC_CHAN_LSB +: 6];
                en_reg <= WB_DAT_I[ATC_EN_BIT];
            end
            if (WB_ADR_I == ATC_ADDR_CTRL1)
                ctrl1_reg <= {WB_DAT_I[7:4], 1'b0, WB_DAT_I[2:0]};
            if (WB_ADR_I == ATC_ADDR_TRIG)
                trig_sel_reg <= WB_DAT_I[4:0];
        end
    end

    // ==========================================================
    // start bit: a start request beats any clear in the same cycle
    assign go_set = en_reg && ((wr_lane && WB_ADR_I == ATC_ADDR_CTRL0
        && WB_DAT_I[ATC_GO_BIT])
        || (trig_edge && !SLEEP));
    // sleep without the rc clock aborts, as does turning the module off
    assign go_clr = (wr_lane && WB_ADR_I == ATC_ADDR_CTRL0
        && !WB_DAT_I[ATC_GO_BIT]) || (load && complete) || !en_reg
        || (SLEEP && !rc_mode);

    always_ff @(posedge CLOCK or posedge RESET)
    begin
        if (RESET)
            go_reg <= 1'b0;
        else if (go_set)
            go_reg <= 1'b1;
        else if (go_clr)
            go_reg <= 1'b0;
    end

    // ==========================================================
    // conversion clock period tick from the divider or rc input
    always_ff @(posedge CLOCK or posedge RESET)
    begin
        if (RESET)
        begin
            div_reg <= 7'h00;
            period_tick_reg <= 1'b0;
        end
        else if (!busy)
        begin
            div_reg <= 7'h00;
            period_tick_reg <= 1'b0;
        end
        else if (rc_mode)
            period_tick_reg <= RC_TICK;
        else if (div_reg == atc_period_div(ctrl1_reg[ATC_CS_LSB +: 3]) - 7'h1)
        begin
            div_reg <= 7'h00;
            period_tick_reg <= 1'b1;
        end
        else
        begin
            div_reg <= div_reg + 7'h1;
            period_tick_reg <= 1'b0;
        end
    end

    // ==========================================================
    // result load and completion flag; flag set beats a clear
    always_ff @(posedge CLOCK or posedge RESET)
    begin
        if (RESET)
        begin
            resh_reg <= 8'h00;
            resl_reg <= 8'h00;
        end
        else if (load)
        begin
            if (ctrl1_reg[ATC_FMT_BIT])
            begin
                resh_reg <= {6'h00, result[9:8]};
                resl_reg <= result[7:0];
            end
            else
            begin
                resh_reg <= result[9:2];
                resl_reg <= {result[1:0], 6'h00};
            end
        end
    end

    always_ff @(posedge CLOCK or posedge RESET)
    begin
        if (RESET)
            flag_reg <= 1'b0;
        else if (load && complete)
            flag_reg <= 1'b1;
        else if (wr_lane && WB_ADR_I == ATC_ADDR_STAT
            && WB_DAT_I[ATC_FLAG_BIT])
            flag_reg <= 1'b0;
    end

    // ==========================================================
    // analog controls; mux opens whole while disabled or on reserved code
    always_ff @(posedge CLOCK or posedge RESET)
    begin
        if (RESET)
        begin
            ANA_ENABLE <= 1'b0;
            ANA_MUX_CONNECT <= 1'b0;
            ANA_CHANNEL <= 6'h00;
            ANA_NREF_EXT <= 1'b0;
            ANA_PREF_SEL <= 2'h0;
            ANA_RC_SEL <= 1'b0;
            CONV_DONE_FLAG <= 1'b0;
        end
        else
        begin
            ANA_ENABLE <= en_reg;
            ANA_MUX_CONNECT <= en_reg && atc_chan_valid(chan_reg);
            ANA_CHANNEL <= chan_reg;
            ANA_NREF_EXT <= en_reg && ctrl1_reg[ATC_NREF_BIT];
            ANA_PREF_SEL <= ctrl1_reg[ATC_PREF_LSB +: 2];
            ANA_RC_SEL <= rc_mode;
            CONV_DONE_FLAG <= flag_reg;
        end
    end

    // ==========================================================
    // submodules
    atc_trig #(.TRIG_N(TRIG_N)) u_trig (
        .clk(CLOCK),
        .rst(RESET),
        .sel(trig_sel_reg),
        .src(TRIG_SRC),
        .edge_pulse(trig_edge)
    );

    atc_sar u_sar (
        .clk(CLOCK),
        .rst(RESET),
        .period_tick(period_tick_reg),
        .go(go_reg),
        .comp_in(COMP_IN),
        .busy(busy),
        .sample(ANA_SAMPLE),
        .trial(ANA_TRIAL),
        .load(load),
        .complete(complete),
        .result(result)
    );

    // ==========================================================
    // checks
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RESET);

    a_trig_sets_go: assert property (
        trig_edge && en_reg && !SLEEP |=> go_reg)
        else $error("trigger edge did not set start bit");
    a_sleep_blocks: assert property (
        trig_edge && SLEEP && !go_reg && !wr_fire |=> !go_reg)
        else $error("trigger started conversion in sleep");
    a_done_clears: assert property (
        load && complete && !go_set |=> !go_reg && flag_reg)
        else $error("completion did not clear start or set flag");
    a_fmt_right: assert property (
        load && ctrl1_reg[ATC_FMT_BIT] |=> resh_reg[7:2] == 6'h00
            && resl_reg == $past(result[7:0]))
        else $error("right justified load wrong");
    a_fmt_left: assert property (
        load && !ctrl1_reg[ATC_FMT_BIT] |=> resl_reg[5:0] == 6'h00
            && resh_reg == $past(result[9:2]))
        else $error("left justified load wrong");
    a_off_open: assert property (
        !en_reg |=> !ANA_MUX_CONNECT && !ANA_NREF_EXT && !ANA_ENABLE)
        else $error("mux connected while disabled");
    a_ack_once: assert property (
        WB_ACK_O |=> !WB_ACK_O)
        else $error("ack held longer than one cycle");
    c_trig_start: cover property (trig_edge && en_reg && !SLEEP);
    c_sleep_edge: cover property (trig_edge && SLEEP);
    c_flag_clear: cover property (flag_reg ##1 !flag_reg);
endmodule

// ==== verif/atc_src_model.sv ====
// partner model: trigger sources, analog comparator and rc oscillator
`timescale 1ns/1ps
module atc_src_model
(
    input wire logic clk,
    input wire logic rst,
    input wire logic fire,
    input wire logic [4:0] fire_idx,
    input wire logic [9:0] trial,
    input wire logic [9:0] target,
    output logic [17:0] trig,
    output logic comp,
    output logic rc_tick
);
    logic [2:0] rc_cnt_reg;

    // ==========================================================
    // sources
    // synchronous levels; timer entries stand for their own flags
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            trig <= 18'h0;
        else
            trig <= fire ? (18'h1 << fire_idx) : 18'h0;
    end

    // ==========================================================
    // analog stage
    // keeps a trial bit while the trial is not above the input level
    assign comp = (trial <= target);
    // free running, so tick phase is unrelated to the start
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            rc_cnt_reg <= 3'h0;
        else
            rc_cnt_reg <= (rc_cnt_reg == 3'h6) ? 3'h0 : rc_cnt_reg + 3'h1;
    end
    assign rc_tick = (rc_cnt_reg == 3'h6);
endmodule

// ==== verif/tb_top.sv ====
// self-checking bench for the converter control block
`timescale 1ns/1ps
module tb_top
    import atc_pkg::*;
;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic cyc, stb, we, sleep, fire, comp, rc_tick, ack, en, conn, nref, rcs;
    logic smp, done_flag;
    logic [3:0] sel;
    logic [7:0] adr, rd;
    logic [31:0] dati, dato, seed;
    logic [4:0] fire_idx;
    logic [9:0] target, trial;
    logic [17:0] trig;
    logic [5:0] chan;
    logic [1:0] pref;
    int miscompares = 0;
    int checked = 0;
    int cycles = 0;
    int divs[8] = '{2, 8, 32, 0, 4, 16, 64, 0};
    logic [7:0] zero_addrs[7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14,
        8'h1c};

    atc_top dut (.CLOCK(clock), .RESET(reset), .WB_CYC_I(cyc),
        .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
        .WB_DAT_I(dati), .WB_DAT_O(dato), .WB_ACK_O(ack), .TRIG_SRC(trig),
        .SLEEP(sleep), .RC_TICK(rc_tick), .COMP_IN(comp), .ANA_ENABLE(en),
        .ANA_MUX_CONNECT(conn), .ANA_CHANNEL(chan), .ANA_NREF_EXT(nref),
        .ANA_PREF_SEL(pref), .ANA_RC_SEL(rcs), .ANA_SAMPLE(smp),
        .ANA_TRIAL(trial), .CONV_DONE_FLAG(done_flag));

    atc_src_model far (.clk(clock), .rst(reset), .fire(fire),
        .fire_idx(fire_idx), .trial(trial), .target(target), .trig(trig),
        .comp(comp), .rc_tick(rc_tick));

    // ==========================================================
    // clock, cycle count, helpers
    always #5 clock = ~clock;
    always @(posedge clock)
        cycles++;

    task automatic give_verdict();
        if (miscompares == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input logic [9:0] got, input logic [9:0] exp);
        checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // xorshift step for the random input levels
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        xorshift = x ^ (x << 5);
    endfunction

    // classic single cycle; hold everything until ack is sampled high
    task automatic bus(input logic w, input logic [7:0] a,
        input logic [7:0] d);
        @(posedge clock);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dati <= {24'h0, d};
        do
        begin
            @(posedge clock);
        end while (ack !== 1'b1);
        rd = dato[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    // polls the start bit; a conversion that never ends counts as a fault
    task automatic wait_done();
        int n;
        for (n = 0; n < 600; n++)
        begin
            bus(1'b0, 8'h00, 8'h00);
            if (rd[1] === 1'b0)
                break;
        end
        if (n == 600)
            miscompares++;
    endtask

    // expected result bytes worked out from the target and the format
    task automatic check_result(input logic fmt);
        int r;
        r = target;
        bus(1'b0, 8'h0c, 8'h00);
        chk(rd, fmt ? (r >> 8) : (r >> 2));
        bus(1'b0, 8'h10, 8'h00);
        chk(rd, fmt ? (r & 255) : ((r & 3) << 6));
        bus(1'b0, 8'h14, 8'h00);
        chk(rd, 10'h1);
        chk(done_flag, 1'b1);
        bus(1'b1, 8'h14, 8'h01);
    endtask

    task automatic pulse(input logic [4:0] idx, input int n);
        fire_idx <= idx;
        fire <= 1'b1;
        repeat (n) @(posedge clock);
        fire <= 1'b0;
        repeat (6) @(posedge clock);
        bus(1'b0, 8'h00, 8'h00);
    endtask

    // ==========================================================
    // watchdog, a generous multiple of the expected run length
    initial
    begin
        repeat (60000) @(posedge clock);
        miscompares++;
        give_verdict();
    end

    // ==========================================================
    // main sequence
    initial
    begin
        int t0;
        {cyc, stb, we, sleep, fire} = 5'h0;
        sel = 4'h1;
        adr = 8'h00;
        dati = 32'h0;
        fire_idx = 5'h0;
        target = 10'h0;
        seed = 32'd38133;
        repeat (12) @(posedge clock);
        reset <= 1'b0;
        foreach (zero_addrs[i])
        begin
            bus(1'b0, zero_addrs[i], 8'h00);
            chk(rd, 10'h0);
        end
        // disabled module keeps every input open
        bus(1'b1, 8'h04, 8'h04);
        bus(1'b1, 8'h00, 8'hf0);
        repeat (3) @(posedge clock);
        chk({en, conn, nref}, 10'h0);
        bus(1'b1, 8'h00, 8'h0d);
        repeat (3) @(posedge clock);
        chk({en, conn}, 10'h2);
        bus(1'b1, 8'h00, 8'hf1);
        repeat (3) @(posedge clock);
        chk({conn, nref, chan}, {4'h0, 6'h3c} | 10'h0c0);
        bus(1'b1, 8'h08, 8'hff);
        bus(1'b0, 8'h08, 8'h00);
        chk(rd, 10'h1f);
        // every clock code, random input level, alternating format
        for (int c = 0; c < 8; c++)
        begin
            seed = xorshift(seed);
            target = seed[9:0];
            bus(1'b1, 8'h04, {c[0], c[2:0], 2'b00, c[1:0]});
            bus(1'b1, 8'h00, 8'h01);
            repeat (3) @(posedge clock);
            chk({rcs, pref}, {c[1:0] == 2'b11, c[1:0]});
            repeat (20) @(posedge clock); // settle after channel set
            t0 = cycles;
            bus(1'b1, 8'h00, 8'h03);
            repeat (2) @(posedge clock);
            chk(smp, 1'b1);
            wait_done();
            t0 = cycles - t0;
            if (divs[c] != 0)
                chk(t0 >= 12*divs[c] && t0 <= 13*divs[c] + 16, 1);
            check_result(c[0]);
        end
        // each trigger source, left high through the conversion
        bus(1'b1, 8'h04, 8'h80);
        for (int k = 1; k < 18; k++)
        begin
            target = 10'(k * 37);
            bus(1'b1, 8'h08, k[7:0]);
            pulse(5'((k % 17) + 1), 2);
            chk(rd[1], 1'b0);
            fire_idx <= k[4:0];
            fire <= 1'b1;
            repeat (6) @(posedge clock);
            bus(1'b0, 8'h00, 8'h00);
            chk(rd[1], 1'b1);
            wait_done();
            check_result(1'b1);
            repeat (8) @(posedge clock);
            bus(1'b0, 8'h00, 8'h00);
            chk(rd[1], 1'b0);
            fire <= 1'b0;
            repeat (4) @(posedge clock);
        end
        // select code zero and sleep both refuse trigger edges
        bus(1'b1, 8'h08, 8'h00);
        pulse(5'h0, 1);
        chk(rd[1], 1'b0);
        // rc clock, so only the trigger gate can keep the start bit low
        bus(1'b1, 8'h04, 8'h30);
        bus(1'b1, 8'h08, 8'h05);
        sleep <= 1'b1;
        pulse(5'h5, 1);
        chk(rd[1], 1'b0);
        sleep <= 1'b0;
        give_verdict();
    end
endmodule
